// >>> hdl/cmpmi_pkg.sv
// package for the comparator mode and mismatch interrupt block
// assumes an AXI4-Lite register bus, 32-bit data, one clock
package cmpmi_pkg;
  // register byte offsets
  localparam logic [3:0] CMPMI_OFF_CTRL = 4'h0;
  localparam logic [3:0] CMPMI_OFF_CFG2 = 4'h4;
  localparam logic [3:0] CMPMI_OFF_IRQ = 4'h8;
  localparam logic [3:0] CMPMI_OFF_PORT = 4'hC;
  // control register fields
  localparam int CMPMI_CTRL_OUT_BIT = 6;
  localparam int CMPMI_CTRL_INV_BIT = 4;
  localparam int CMPMI_CTRL_SW_BIT = 3;
  // config2 fields
  localparam int CMPMI_CFG2_GSS_BIT = 1;
  localparam int CMPMI_CFG2_SYNC_BIT = 0;
  // irq register fields
  localparam int CMPMI_IRQ_FLAG_BIT = 0;
  localparam int CMPMI_IRQ_CIE_BIT = 1;
  localparam int CMPMI_IRQ_PIE_BIT = 2;
  localparam int CMPMI_IRQ_GIE_BIT = 3;
  // reset values
  localparam logic [2:0] CMPMI_MODE_RST = 3'h0;
  localparam logic CMPMI_GSS_RST = 1'b1;
  localparam logic CMPMI_SYNC_RST = 1'b0;
  // phase divider: four clocks per instruction cycle
  localparam logic [1:0] CMPMI_PHASE_LAST = 2'h3;
  // axi responses
  localparam logic [1:0] CMPMI_RESP_OKAY = 2'h0;
  localparam logic [1:0] CMPMI_RESP_SLVERR = 2'h2;
  // comparator modes
  typedef enum logic [2:0]
  {
    CMPMI_M_OFF = 3'h0,
    CMPMI_M_OUT = 3'h1,
    CMPMI_M_INT = 3'h2,
    CMPMI_M_REF_OUT = 3'h3,
    CMPMI_M_REF_INT = 3'h4,
    CMPMI_M_MUX_OUT = 3'h5,
    CMPMI_M_MUX_INT = 3'h6,
    CMPMI_M_DIS = 3'h7
  } cmpmi_mode_t;
  // pin role bundle from the mode decode
  typedef struct packed
  {
    logic pos_analog;
    logic neg_analog;
    logic out_drive;
    logic ref_noninv;
    logic mux_inputs;
    logic comp_on;
  } cmpmi_roles_t;
endpackage

// >>> hdl/cmpmi_mode_decode.sv
// pin role decode for the comparator mode field
// assumes a pure combinational use inside the comparator top
`timescale 1ns/1ps
`default_nettype none
module cmpmi_mode_decode
  import cmpmi_pkg::*;
(
  input wire logic [2:0] i_mode,
  output cmpmi_pkg::cmpmi_roles_t o_roles
);
  // one row per mode
  always_comb
  begin
    o_roles = '0;
    case (i_mode)
      CMPMI_M_OFF:
      begin
        o_roles.pos_analog = 1'b1;
        o_roles.neg_analog = 1'b1;
      end
      CMPMI_M_OUT:
      begin
        o_roles.pos_analog = 1'b1;
        o_roles.neg_analog = 1'b1;
        o_roles.out_drive = 1'b1;
        o_roles.comp_on = 1'b1;
      end
      CMPMI_M_INT:
      begin
        o_roles.pos_analog = 1'b1;
        o_roles.neg_analog = 1'b1;
        o_roles.comp_on = 1'b1;
      end
      CMPMI_M_REF_OUT:
      begin
        o_roles.neg_analog = 1'b1;
        o_roles.out_drive = 1'b1;
        o_roles.ref_noninv = 1'b1;
        o_roles.comp_on = 1'b1;
      end
      CMPMI_M_REF_INT:
      begin
        o_roles.neg_analog = 1'b1;
        o_roles.ref_noninv = 1'b1;
        o_roles.comp_on = 1'b1;
      end
      CMPMI_M_MUX_OUT:
      begin
        o_roles.pos_analog = 1'b1;
        o_roles.neg_analog = 1'b1;
        o_roles.out_drive = 1'b1;
        o_roles.ref_noninv = 1'b1;
        o_roles.mux_inputs = 1'b1;
        o_roles.comp_on = 1'b1;
      end
      CMPMI_M_MUX_INT:
      begin
        o_roles.pos_analog = 1'b1;
        o_roles.neg_analog = 1'b1;
        o_roles.ref_noninv = 1'b1;
        o_roles.mux_inputs = 1'b1;
        o_roles.comp_on = 1'b1;
      end
      default:
      begin
        o_roles = '0;
      end
    endcase
  end
endmodule
`default_nettype wire

// >>> hdl/cmpmi_top.sv
// comparator mode control, change-detect interrupt and timer gate select
// assumes AXI4-Lite master, analog core result on i_cmp_raw, one clock
// Notes on behaviour
// - three-bit mode field picks one of eight modes, fixing pins and output
// - port bits of analog pins read back as zero
// - output bit always readable; pin driven only in modes 001, 011, 101
// - output is one when noninverting input higher; invert bit flips it
// - modes 101 and 110: switch bit picks which pin feeds inverting input
// - in other modes the switch bit changes no input connection
// - mode 000 inputs analog, output off; 001 drives output pin
// - modes 011 and 100 use internal reference, positive pin general I/O
// - modes 010, 100, 110 keep output internal, output pin general I/O
// - mode 111 makes all pins general I/O and turns comparator off
// - change latch samples output each phase one; difference sets flag
// - read-capture latch loads output on each control register read
// - persisting mismatch holds the flag; software cannot clear it then
// - a write to the control register also ends the mismatch
// - flag cleared only by writing zero; writing one sets it
// - request needs all three enables; flag sets regardless
// - a change during a control register read or write may be missed by the flag
// - comparator stays on in sleep; modes 000 and 111 power it off
// - output change wakes from sleep when two enables set
// - reset returns both configuration registers, mode 000
// - clearing gate select routes output to the timer gate
// - sync mode latches output on timer clock falling edge
// - config2 resets with gate select one and sync zero
//
// The register addresses and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module cmpmi_top
  import cmpmi_pkg::*;
#(
  parameter int PORT_W = 6,
  parameter int POS_PIN = 0,
  parameter int NEG_PIN = 1,
  parameter int OUT_PIN = 2
)
(
  input wire logic i_clock,
  input wire logic i_rstn,
  // axi4-lite slave
  input wire logic [3:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [3:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // analog core and pins
  input wire logic i_cmp_raw,
  input wire logic [PORT_W-1:0] i_port_pins,
  input wire logic i_sleeping,
  input wire logic i_timer_clk_en,
  output logic o_cmp_enable,
  output logic o_ref_noninv,
  output logic o_inv_from_pos,
  output logic [PORT_W-1:0] o_analog_pins,
  output logic o_out_pin,
  output logic o_out_pin_oe,
  output logic o_timer_gate,
  output logic o_irq,
  output logic o_wake
);
  logic [2:0] mode_r;
  logic invert_r;
  logic switch_r;
  logic gss_r;
  logic sync_r;
  logic flag_r;
  logic cie_r;
  logic pie_r;
  logic gie_r;
  logic [1:0] phase_r;
  logic cmp_out;
  logic change_r;
  logic capture_r;
  logic sync_out_r;
  logic aw_hold_r;
  logic w_hold_r;
  logic [3:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic do_write;
  logic do_read;
  logic ctrl_access;
  logic mismatch;
  logic phase_one;
  cmpmi_roles_t roles;

  // is the byte address the control register
  function automatic logic is_ctrl(input logic [3:0] a);
    is_ctrl = (a[3:2] == CMPMI_OFF_CTRL[3:2]);
  endfunction

  cmpmi_mode_decode u_decode
  (
    .i_mode(mode_r),
    .o_roles(roles)
  );

  // phase divider, phase one is a one-cycle enable
  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
      phase_r <= 2'h0;
    else
      phase_r <= phase_r + 2'h1;
  end
  assign phase_one = (phase_r == 2'h0);

  // polarity applied to the raw result
  assign cmp_out = roles.comp_on & (i_cmp_raw ^ invert_r);

  // write side: address and data accepted in either order
  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
    begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awaddr_r <= 4'h0;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
    end
    else
    begin
      if (i_awvalid && o_awready)
      begin
        aw_hold_r <= 1'b1;
        awaddr_r <= i_awaddr;
      end
      if (i_wvalid && o_wready)
      begin
        w_hold_r <= 1'b1;
        wdata_r <= i_wdata;
        wstrb_r <= i_wstrb;
      end
      if (do_write)
      begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
      end
    end
  end
  assign do_write = aw_hold_r && w_hold_r && !o_bvalid;

  // ready and response flags
  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
    begin
      o_awready <= 1'b0;
      o_wready <= 1'b0;
      o_bvalid <= 1'b0;
      o_bresp <= CMPMI_RESP_OKAY;
    end
    else
    begin
      o_awready <= !aw_hold_r && !(i_awvalid && o_awready) && !o_bvalid;
      o_wready <= !w_hold_r && !(i_wvalid && o_wready) && !o_bvalid;
      if (do_write)
      begin
        o_bvalid <= 1'b1;
        o_bresp <= (awaddr_r[3:2] == CMPMI_OFF_PORT[3:2]) ?
          CMPMI_RESP_SLVERR : CMPMI_RESP_OKAY;
      end
      else if (i_bready)
        o_bvalid <= 1'b0;
    end
  end

  // read channel, one cycle to answer
  assign do_read = i_arvalid && o_arready;
  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
    begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0;
      o_rresp <= CMPMI_RESP_OKAY;
    end
    else
    begin
      o_arready <= !o_rvalid && !do_read;
      if (do_read)
      begin
        o_rvalid <= 1'b1;
        o_rresp <= CMPMI_RESP_OKAY;
        o_rdata <= 32'h0;
        case (i_araddr[3:2])
          CMPMI_OFF_CTRL[3:2]:
          begin
            // bits 7 and 5 stay zero
            o_rdata[CMPMI_CTRL_OUT_BIT] <= cmp_out;
            o_rdata[CMPMI_CTRL_INV_BIT] <= invert_r;
            o_rdata[CMPMI_CTRL_SW_BIT] <= switch_r;
            o_rdata[2:0] <= mode_r;
          end
          CMPMI_OFF_CFG2[3:2]:
          begin
            o_rdata[CMPMI_CFG2_GSS_BIT] <= gss_r;
            o_rdata[CMPMI_CFG2_SYNC_BIT] <= sync_r;
          end
          CMPMI_OFF_IRQ[3:2]:
          begin
            o_rdata[CMPMI_IRQ_FLAG_BIT] <= flag_r;
            o_rdata[CMPMI_IRQ_CIE_BIT] <= cie_r;
            o_rdata[CMPMI_IRQ_PIE_BIT] <= pie_r;
            o_rdata[CMPMI_IRQ_GIE_BIT] <= gie_r;
          end
          default:
          begin
            o_rdata[PORT_W-1:0] <= i_port_pins & ~o_analog_pins;
          end
        endcase
      end
      else if (i_rready)
        o_rvalid <= 1'b0;
    end
  end

  // configuration registers, low byte lane only
  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
    begin
      mode_r <= CMPMI_MODE_RST;
      invert_r <= 1'b0;
      switch_r <= 1'b0;
      gss_r <= CMPMI_GSS_RST;
      sync_r <= CMPMI_SYNC_RST;
      cie_r <= 1'b0;
      pie_r <= 1'b0;
      gie_r <= 1'b0;
    end
    else if (do_write && wstrb_r[0])
    begin
      case (awaddr_r[3:2])
        CMPMI_OFF_CTRL[3:2]:
        begin
          mode_r <= wdata_r[2:0];
          invert_r <= wdata_r[CMPMI_CTRL_INV_BIT];
          switch_r <= wdata_r[CMPMI_CTRL_SW_BIT];
        end
        CMPMI_OFF_CFG2[3:2]:
        begin
          gss_r <= wdata_r[CMPMI_CFG2_GSS_BIT];
          sync_r <= wdata_r[CMPMI_CFG2_SYNC_BIT];
        end
        CMPMI_OFF_IRQ[3:2]:
        begin
          cie_r <= wdata_r[CMPMI_IRQ_CIE_BIT];
          pie_r <= wdata_r[CMPMI_IRQ_PIE_BIT];
          gie_r <= wdata_r[CMPMI_IRQ_GIE_BIT];
        end
        default:
        begin
          mode_r <= mode_r;
        end
      endcase
    end
  end

  // any control read or write reloads the capture latch
  assign ctrl_access = (do_read && is_ctrl(i_araddr)) ||
    (do_write && is_ctrl(awaddr_r));
  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
      capture_r <= 1'b0;
    else if (ctrl_access)
      capture_r <= cmp_out;
  end

  // change latch sampled on phase one only
  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
      change_r <= 1'b0;
    else if (phase_one)
      change_r <= cmp_out;
  end
  assign mismatch = change_r ^ capture_r;

  // interrupt flag; set wins over a software clear
  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
      flag_r <= 1'b0;
    // set dropped during a control access
    else if (mismatch && !ctrl_access)
      flag_r <= 1'b1;
    else if (do_write && wstrb_r[0] && awaddr_r[3:2] == CMPMI_OFF_IRQ[3:2])
      flag_r <= wdata_r[CMPMI_IRQ_FLAG_BIT];
  end

  // sync latch on timer clock falling-edge enable
  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
      sync_out_r <= 1'b0;
    else if (i_timer_clk_en)
      sync_out_r <= cmp_out;
  end

  // pin and analog outputs, all registered
  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
    begin
      o_cmp_enable <= 1'b0;
      o_ref_noninv <= 1'b0;
      o_inv_from_pos <= 1'b0;
      o_analog_pins <= '0;
      o_out_pin <= 1'b0;
      o_out_pin_oe <= 1'b0;
      o_timer_gate <= 1'b0;
      o_irq <= 1'b0;
      o_wake <= 1'b0;
    end
    else
    begin
      // modes 000 and 111 power down
      // mode 111 all pins general I/O
      o_cmp_enable <= roles.comp_on;
      o_ref_noninv <= roles.ref_noninv;
      o_inv_from_pos <= roles.mux_inputs & switch_r;
      o_analog_pins <= '0;
      o_analog_pins[POS_PIN] <= roles.pos_analog;
      o_analog_pins[NEG_PIN] <= roles.neg_analog;
      // pin driven only in output modes
      o_out_pin <= roles.out_drive & cmp_out;
      o_out_pin_oe <= roles.out_drive;
      // gate source select low picks comparator
      o_timer_gate <= !gss_r && (sync_r ? sync_out_r : cmp_out);
      o_irq <= flag_r && cie_r && pie_r && gie_r;
      o_wake <= flag_r && cie_r && pie_r && i_sleeping;
    end
  end
endmodule
`default_nettype wire

// >>> testbench/cmpmi_checker_assertions.sv
// port checker for the comparator control block
// assumes binding into cmpmi_top, one clock domain
`timescale 1ns/1ps
`default_nettype none
module cmpmi_checker
  import cmpmi_pkg::*;
#(
  parameter int PORT_W = 6
)
(
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic [3:0] i_araddr,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic [31:0] o_rdata,
  input wire logic o_rvalid,
  input wire logic i_rready,
  input wire logic i_sleeping,
  input wire logic o_cmp_enable,
  input wire logic o_ref_noninv,
  input wire logic o_inv_from_pos,
  input wire logic [PORT_W-1:0] o_analog_pins,
  input wire logic o_out_pin,
  input wire logic o_out_pin_oe,
  input wire logic o_timer_gate,
  input wire logic o_irq,
  input wire logic o_wake
);
  logic [3:0] ar_q;
  default clocking @(posedge i_clock);
  endclocking
  default disable iff (!i_rstn);
  // address of the read in flight, to know what rdata carries
  always_ff @(posedge i_clock)
  begin
    if (i_arvalid && o_arready)
    begin
      ar_q <= i_araddr;
    end
  end
  property p_oe;
    o_out_pin_oe |-> o_cmp_enable && o_analog_pins[1];
  endproperty
  a_oe: assert property (p_oe)
    else $error("output pin driven in a wrong mode");
  property p_off;
    !o_cmp_enable |-> !o_ref_noninv && !o_inv_from_pos && !o_out_pin_oe;
  endproperty
  a_off: assert property (p_off)
    else $error("comparator off but routing active");
  property p_mux;
    o_inv_from_pos |-> o_ref_noninv && (o_analog_pins[1:0] == 2'h3);
  endproperty
  a_mux: assert property (p_mux)
    else $error("input switch outside muxed modes");
  property p_ref;
    o_ref_noninv |-> o_analog_pins[1];
  endproperty
  a_ref: assert property (p_ref)
    else $error("reference mode without analog negative pin");
  property p_wake;
    o_wake |-> $past(i_sleeping);
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake while not sleeping");
  property p_irq_wake;
    o_irq && $past(i_sleeping) |-> o_wake;
  endproperty
  a_irq_wake: assert property (p_irq_wake)
    else $error("enabled request in sleep gave no wake");
  property p_rst;
    $rose(i_rstn) |-> (!o_cmp_enable && !o_irq) [*3];
  endproperty
  a_rst: assert property (p_rst)
    else $error("comparator active after reset");
  property p_ctl_rd;
    o_rvalid && ar_q == CMPMI_OFF_CTRL
      |-> o_rdata[31:7] == 25'h0 && !o_rdata[5];
  endproperty
  a_ctl_rd: assert property (p_ctl_rd)
    else $error("unused control bits read nonzero");
  property p_port;
    o_rvalid && ar_q == CMPMI_OFF_PORT
      |-> (o_rdata[PORT_W-1:0] & o_analog_pins) == '0;
  endproperty
  a_port: assert property (p_port)
    else $error("analog pin read back as one");
  property p_comparator_out;
    o_rvalid && ar_q == CMPMI_OFF_CTRL && o_out_pin_oe
      |-> o_rdata[CMPMI_CTRL_OUT_BIT] == o_out_pin;
  endproperty
  a_comparator_out: assert property (p_comparator_out)
    else $error("status bit differs from output pin");
  property p_gate;
    o_timer_gate |-> o_cmp_enable;
  endproperty
  a_gate: assert property (p_gate)
    else $error("timer gate high with comparator off");
endmodule
bind cmpmi_top cmpmi_checker #(.PORT_W(PORT_W)) chk_u (.*);
`default_nettype wire

// >>> testbench/cmpmi_core_model.sv
// behavioural analog comparator core with bench-set voltages
// assumes the role outputs of cmpmi_top; one cycle response
`timescale 1ns/1ps
`default_nettype none
module cmpmi_core_model
(
  input wire logic i_clock,
  input wire logic i_en,
  input wire logic i_ref,
  input wire logic i_ipos,
  output logic o_raw
);
  int v_pos = 3;
  int v_neg = 1;
  int v_ref = 2;
  initial o_raw = 1'h0;
  // compare routed inputs
  // unpowered core gives a changing level, never a held one
  // plain always, so the start-up value above is not a second driver
  always @(posedge i_clock)
  begin
    o_raw <= i_en ? ((i_ref ? v_ref : v_pos) > (i_ipos ? v_pos : v_neg))
      : !o_raw;
  end
endmodule
`default_nettype wire

// >>> testbench/cmpmi_top_test.sv
// self-checking bench for the comparator control block
// assumes the core model and the bound checker
`timescale 1ns/1ps
`default_nettype none
module cmpmi_top_test;
  import cmpmi_pkg::*;
  typedef struct packed
  {
    logic [2:0] m;
    logic en, rf, ip, oe;
    logic [1:0] an;
  } cmpmi_row_t;
  logic clk, rstn, awvalid, wvalid, bready, arvalid, rready;
  logic sleeping, tclk_en, c, iv;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, d;
  logic awready, wready, bvalid, arready, rvalid, raw, cmp_en, ref_n;
  logic ipos, pin, pin_oe, gate, irq, wake;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [5:0] an;
  int miscompares = 0;
  int comparisons = 0;
  int i, s;
  cmpmi_row_t r;
  // mode, {enable, ref, switch used, pin drive}, analog pins
  cmpmi_row_t rows [8] = '{{3'h0, 4'h0, 2'h3}, {3'h1, 4'h9, 2'h3},
    {3'h2, 4'h8, 2'h3}, {3'h3, 4'hD, 2'h2}, {3'h4, 4'hC, 2'h2},
    {3'h5, 4'hF, 2'h3}, {3'h6, 4'hE, 2'h3}, {3'h7, 4'h0, 2'h0}};
  cmpmi_top dut_u (.i_clock(clk), .i_rstn(rstn), .i_awaddr(awaddr),
    .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
    .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready),
    .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
    .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
    .i_rready(rready), .i_cmp_raw(raw), .i_port_pins(6'h3F),
    .i_sleeping(sleeping), .i_timer_clk_en(tclk_en),
    .o_cmp_enable(cmp_en), .o_ref_noninv(ref_n),
    .o_inv_from_pos(ipos), .o_analog_pins(an), .o_out_pin(pin),
    .o_out_pin_oe(pin_oe), .o_timer_gate(gate), .o_irq(irq),
    .o_wake(wake));
  cmpmi_core_model core_u (.i_clock(clk), .i_en(cmp_en), .i_ref(ref_n),
    .i_ipos(ipos), .o_raw(raw));
  // 100 ns system clock
  initial
  begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    if (miscompares == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // one write; address and data offered together, held until taken
  task automatic wr(input logic [3:0] a, input logic [31:0] v,
    input logic [1:0] er);
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (int n = 0; n < 40; n++)
    begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      if (bvalid) break;
    end
    chk({bvalid, bresp}, {1'h1, er});
    bready <= 1'h0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (int n = 0; n < 40; n++)
    begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'h0;
      if (rvalid) break;
    end
    v = rdata;
    chk(rvalid, 1'h1);
    rready <= 1'h0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
    rd(a, d);
    chk(d, e);
  endtask
  // reset values of all three registers
  task automatic rst_chk;
    rd_chk(CMPMI_OFF_CTRL, 32'h0);
    rd_chk(CMPMI_OFF_CFG2, 32'h2);
    rd_chk(CMPMI_OFF_IRQ, 32'h0);
    chk(cmp_en, 1'h0);
  endtask
  // watchdog, well beyond the expected few hundred cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    miscompares++;
    complete_run();
  end
  initial
  begin
    {rstn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    {sleeping, tclk_en, awaddr, araddr} = 10'h0;
    wstrb = 4'hF;
    wdata = 32'h0;
    repeat (5) @(posedge clk);
    rstn <= 1'h1;
    rst_chk();
    chk(gate, 1'h0);
    for (s = 0; s < 2; s++)
      for (i = 0; i < 8; i++)
      begin
        r = rows[i];
        iv = i[1];
        c = r.en & (((r.rf ? 2 : 3) > ((r.ip & s[0]) ? 3 : 1)) ^ iv);
        // pin direction taken as cleared in driving modes
        wr(CMPMI_OFF_CTRL, {27'h0, iv, s[0], r.m}, CMPMI_RESP_OKAY);
        repeat (4) @(posedge clk);
        chk(cmp_en, r.en);
        chk(ref_n, r.rf);
        chk(ipos, r.ip & s[0]);
        chk(an[1:0], r.an);
        chk(pin_oe, r.oe);
        if (r.oe) chk(pin, c);
        rd_chk(CMPMI_OFF_CTRL, {25'h0, c, 1'h0, iv, s[0], r.m});
        rd(CMPMI_OFF_PORT, d);
        chk(d[1:0], {30'h0, ~r.an});
      end
    wr(CMPMI_OFF_PORT, 32'h0, CMPMI_RESP_SLVERR);
    wr(CMPMI_OFF_CTRL, 32'h2, CMPMI_RESP_OKAY);
    repeat (8) @(posedge clk);
    // mismatch and flag cleared before enabling
    rd(CMPMI_OFF_CTRL, d);
    wr(CMPMI_OFF_IRQ, 32'h0, CMPMI_RESP_OKAY);
    rd_chk(CMPMI_OFF_IRQ, 32'h0);
    core_u.v_pos = 0;
    repeat (8) @(posedge clk);
    rd_chk(CMPMI_OFF_IRQ, 32'h1);
    chk(irq, 1'h0);
    wr(CMPMI_OFF_IRQ, 32'h0, CMPMI_RESP_OKAY);
    rd_chk(CMPMI_OFF_IRQ, 32'h1);
    rd(CMPMI_OFF_CTRL, d);
    wr(CMPMI_OFF_IRQ, 32'hE, CMPMI_RESP_OKAY);
    rd_chk(CMPMI_OFF_IRQ, 32'hE);
    sleeping <= 1'h1;
    core_u.v_pos = 3;
    repeat (8) @(posedge clk);
    chk(irq, 1'h1);
    chk(wake, 1'h1);
    core_u.v_pos = 0;
    repeat (8) @(posedge clk);
    wr(CMPMI_OFF_IRQ, 32'hE, CMPMI_RESP_OKAY);
    rd_chk(CMPMI_OFF_IRQ, 32'hE);
    core_u.v_pos = 3;
    repeat (8) @(posedge clk);
    wr(CMPMI_OFF_CTRL, 32'hE2, CMPMI_RESP_OKAY);
    wr(CMPMI_OFF_IRQ, 32'hE, CMPMI_RESP_OKAY);
    rd_chk(CMPMI_OFF_IRQ, 32'hE);
    rd_chk(CMPMI_OFF_CTRL, 32'h42);
    wr(CMPMI_OFF_IRQ, 32'hF, CMPMI_RESP_OKAY);
    rd_chk(CMPMI_OFF_IRQ, 32'hF);
    wr(CMPMI_OFF_CFG2, 32'h0, CMPMI_RESP_OKAY);
    repeat (4) @(posedge clk);
    chk(gate, 1'h1);
    wr(CMPMI_OFF_CFG2, 32'h1, CMPMI_RESP_OKAY);
    // one timer edge first, so the latch holds the current high output
    tclk_en <= 1'h1;
    @(posedge clk);
    tclk_en <= 1'h0;
    core_u.v_pos = 0;
    repeat (8) @(posedge clk);
    chk(gate, 1'h1);
    tclk_en <= 1'h1;
    @(posedge clk);
    tclk_en <= 1'h0;
    repeat (3) @(posedge clk);
    chk(gate, 1'h0);
    rstn <= 1'h0;
    repeat (5) @(posedge clk);
    rstn <= 1'h1;
    rst_chk();
    complete_run();
  end
endmodule
`default_nettype wire
